// ==== cbrf_pkg.sv ====
// constants for the banked cpu register file
// assumes a 32-bit core with one clock and a synchronous active-low reset
`default_nettype none
package cbrf_pkg;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned REG_IDX_W   = 4;
    localparam int unsigned BANK_IDX_W  = 3;
    localparam int unsigned BANK_DEPTH  = 8;
    localparam int unsigned HIGH_DEPTH  = 8;
    localparam logic [2:0]  INDEX_REG   = 3'h0;

    // status word layout
    localparam int unsigned MD_BIT      = 30;
    localparam int unsigned RB_BIT      = 29;
    localparam int unsigned BL_BIT      = 28;
    localparam logic [31:0] STATUS_RESET = 32'h700000f0;
    localparam logic [31:0] STATUS_WMASK = 32'h700003f3;

    localparam logic [31:0] PC_RESET    = 32'ha0000000;
    localparam logic [31:0] VBR_RESET   = 32'h00000000;
    localparam logic [31:0] INSTR_BYTES = 32'h00000002;
    localparam logic [31:0] PC_AHEAD    = 32'h00000004;

    // system register select
    localparam logic [1:0]  SYS_ACC_HIGH = 2'h0;
    localparam logic [1:0]  SYS_ACC_LOW  = 2'h1;
    localparam logic [1:0]  SYS_PROC_RET = 2'h2;
    localparam logic [1:0]  SYS_PROG_CNT = 2'h3;

    // control register select; 8..15 reach the non-selected bank
    localparam logic [3:0]  CTL_STATUS      = 4'h0;
    localparam logic [3:0]  CTL_SAVED_STAT  = 4'h1;
    localparam logic [3:0]  CTL_SAVED_PC    = 4'h2;
    localparam logic [3:0]  CTL_GLOBAL_BASE = 4'h3;
    localparam logic [3:0]  CTL_VECTOR_BASE = 4'h4;
    localparam int unsigned CTL_BANK_BIT    = 3;
endpackage
`default_nettype wire

// ==== cbrf_bank.sv ====
// one bank of general registers, one write port, three indexed read ports and a fixed read of entry 0
// assumes the caller never writes a bank from two sources in one cycle
`timescale 1ns/10ps
`default_nettype none
module cbrf_bank #(
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW    = 3
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] widx_i,
    input  wire logic [31:0]   wdata_i,
    input  wire logic [AW-1:0] ridx_a_i,
    input  wire logic [AW-1:0] ridx_b_i,
    input  wire logic [AW-1:0] ridx_c_i,
    output logic      [31:0]   rdata_a_o,
    output logic      [31:0]   rdata_b_o,
    output logic      [31:0]   rdata_c_o,
    output logic      [31:0]   rdata_r0_o
);
    logic [31:0] mem [DEPTH];

    // no reset: contents are undefined after reset
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[widx_i] <= wdata_i;
        end
    end

    assign rdata_a_o  = mem[ridx_a_i];
    assign rdata_b_o  = mem[ridx_b_i];
    assign rdata_c_o  = mem[ridx_c_i];
    assign rdata_r0_o = mem[0];
endmodule // cbrf_bank
`default_nettype wire

// ==== cbrf_regfile.sv ====
// architectural register set of the core: general, system and control registers
// assumes decode/execute logic drives the request ports synchronously to sys_clk_i
`timescale 1ns/10ps
`default_nettype none
module cbrf_regfile (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // general register ports
    input  wire logic [3:0]  rd_a_idx_i,
    input  wire logic [3:0]  rd_b_idx_i,
    input  wire logic        gen_we_i,
    input  wire logic [3:0]  gen_wr_idx_i,
    input  wire logic [31:0] gen_wr_data_i,
    output logic      [31:0] rd_a_data_o,
    output logic      [31:0] rd_b_data_o,
    output logic      [31:0] index_data_o,
    // system register transfers
    input  wire logic        sys_we_i,
    input  wire logic        sys_re_i,
    input  wire logic [1:0]  sys_sel_i,
    input  wire logic [31:0] sys_wdata_i,
    output logic      [31:0] sys_rdata_o,
    // control register transfers
    input  wire logic        ctl_we_i,
    input  wire logic        ctl_re_i,
    input  wire logic [3:0]  ctl_sel_i,
    input  wire logic [31:0] ctl_wdata_i,
    output logic      [31:0] ctl_rdata_o,
    output logic             ctl_fault_o,
    // execution side updates
    input  wire logic        mac_we_i,
    input  wire logic [31:0] mac_high_i,
    input  wire logic [31:0] mac_low_i,
    input  wire logic        pr_we_i,
    input  wire logic [31:0] pr_wdata_i,
    input  wire logic        pc_advance_i,
    input  wire logic        pc_load_i,
    input  wire logic [31:0] pc_target_i,
    input  wire logic        exc_take_i,
    input  wire logic [31:0] exc_target_i,
    input  wire logic        exc_return_i,
    // state seen by the core
    output logic      [31:0] pc_o,
    output logic      [31:0] status_o,
    output logic      [31:0] global_base_o,
    output logic      [31:0] vector_base_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] pc_reg;
    logic [31:0] status_reg;
    logic [31:0] saved_status_reg;
    logic [31:0] saved_pc_reg;
    logic [31:0] global_base_reg;
    logic [31:0] vector_base_reg;
    logic [31:0] acc_high_reg;
    logic [31:0] acc_low_reg;
    logic [31:0] proc_ret_reg;
    logic [31:0] high_regs [cbrf_pkg::HIGH_DEPTH];

    logic [31:0] rd_a_reg;
    logic [31:0] rd_b_reg;
    logic [31:0] index_reg;
    logic [31:0] sys_rdata_reg;
    logic [31:0] ctl_rdata_reg;
    logic        ctl_fault_reg;

    logic        priv_mode;
    logic        bank_cur;
    logic        ctl_ok;
    logic        ctl_wr_ok;
    logic        alt_we;
    logic        gen_lo_we;
    logic        gen_hi_we;
    logic        bank0_we;
    logic        bank1_we;
    logic [2:0]  bank0_widx;
    logic [2:0]  bank1_widx;
    logic [31:0] b0_a;
    logic [31:0] b0_b;
    logic [31:0] b0_c;
    logic [31:0] b0_r0;
    logic [31:0] b1_a;
    logic [31:0] b1_b;
    logic [31:0] b1_c;
    logic [31:0] b1_r0;
    logic [31:0] rd_a_next;
    logic [31:0] rd_b_next;
    logic [31:0] index_next;
    logic [31:0] alt_rdata;
    logic [31:0] ctl_rdata_next;
    logic [31:0] sys_rdata_next;

    ////////////////////////////////////////////////////////////////////////////
    // bank steering
    assign priv_mode = status_reg[cbrf_pkg::MD_BIT];
    // user mode always sees bank zero
    assign bank_cur  = priv_mode & status_reg[cbrf_pkg::RB_BIT];
    assign ctl_ok    = priv_mode | (ctl_sel_i == cbrf_pkg::CTL_GLOBAL_BASE);
    assign ctl_wr_ok = ctl_we_i & ctl_ok;
    assign alt_we    = ctl_wr_ok & ctl_sel_i[cbrf_pkg::CTL_BANK_BIT];
    assign gen_lo_we = gen_we_i & ~gen_wr_idx_i[3];
    assign gen_hi_we = gen_we_i & gen_wr_idx_i[3];

    // a general write goes to the current bank and a control write to the
    // other one, so a bank never sees two writers in one cycle
    always_comb begin
        bank0_we   = (gen_lo_we & ~bank_cur) | (alt_we & bank_cur);
        bank1_we   = (gen_lo_we & bank_cur) | (alt_we & ~bank_cur);
        bank0_widx = (gen_lo_we & ~bank_cur) ? gen_wr_idx_i[2:0] : ctl_sel_i[2:0];
        bank1_widx = (gen_lo_we & bank_cur) ? gen_wr_idx_i[2:0] : ctl_sel_i[2:0];
    end

    cbrf_bank #(
        .DEPTH (cbrf_pkg::BANK_DEPTH),
        .AW    (cbrf_pkg::BANK_IDX_W)
    ) u_bank_zero (
        .clk_i      (sys_clk_i),
        .we_i       (bank0_we),
        .widx_i     (bank0_widx),
        .wdata_i    (alt_we & bank_cur & ~(gen_lo_we & ~bank_cur) ? ctl_wdata_i
                                                                   : gen_wr_data_i),
        .ridx_a_i   (rd_a_idx_i[2:0]),
        .ridx_b_i   (rd_b_idx_i[2:0]),
        .ridx_c_i   (ctl_sel_i[2:0]),
        .rdata_a_o  (b0_a),
        .rdata_b_o  (b0_b),
        .rdata_c_o  (b0_c),
        .rdata_r0_o (b0_r0)
    );

    cbrf_bank #(
        .DEPTH (cbrf_pkg::BANK_DEPTH),
        .AW    (cbrf_pkg::BANK_IDX_W)
    ) u_bank_one (
        .clk_i      (sys_clk_i),
        .we_i       (bank1_we),
        .widx_i     (bank1_widx),
        .wdata_i    (alt_we & ~bank_cur & ~(gen_lo_we & bank_cur) ? ctl_wdata_i
                                                                   : gen_wr_data_i),
        .ridx_a_i   (rd_a_idx_i[2:0]),
        .ridx_b_i   (rd_b_idx_i[2:0]),
        .ridx_c_i   (ctl_sel_i[2:0]),
        .rdata_a_o  (b1_a),
        .rdata_b_o  (b1_b),
        .rdata_c_o  (b1_c),
        .rdata_r0_o (b1_r0)
    );

    // upper eight general registers, shared by both modes, not reset
    always_ff @(posedge sys_clk_i) begin
        if (gen_hi_we) begin
            high_regs[gen_wr_idx_i[2:0]] <= gen_wr_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // general read ports, registered: data appears the cycle after the index
    always_comb begin
        rd_a_next  = rd_a_idx_i[3] ? high_regs[rd_a_idx_i[2:0]]
                                   : (bank_cur ? b1_a : b0_a);
        rd_b_next  = rd_b_idx_i[3] ? high_regs[rd_b_idx_i[2:0]]
                                   : (bank_cur ? b1_b : b0_b);
        // dedicated path for the index / fixed-operand register
        index_next = bank_cur ? b1_r0 : b0_r0;
        alt_rdata  = bank_cur ? b0_c : b1_c;
    end

    always_ff @(posedge sys_clk_i) begin
        rd_a_reg  <= rd_a_next;
        rd_b_reg  <= rd_b_next;
        index_reg <= index_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter; held four bytes ahead of the executing instruction
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pc_reg <= cbrf_pkg::PC_RESET;
        end else if (exc_take_i) begin
            pc_reg <= exc_target_i;
        end else if (exc_return_i) begin
            pc_reg <= saved_pc_reg;
        end else if (pc_load_i) begin
            pc_reg <= pc_target_i;
        end else if (pc_advance_i) begin
            pc_reg <= pc_reg + cbrf_pkg::INSTR_BYTES;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status word; exception entry beats any software write in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            status_reg <= cbrf_pkg::STATUS_RESET;
        end else if (exc_take_i) begin
            status_reg <= status_reg | cbrf_pkg::STATUS_RESET
                          & ~cbrf_pkg::STATUS_WMASK
                          | (32'h1 << cbrf_pkg::MD_BIT)
                          | (32'h1 << cbrf_pkg::RB_BIT)
                          | (32'h1 << cbrf_pkg::BL_BIT);
        end else if (exc_return_i) begin
            status_reg <= saved_status_reg & cbrf_pkg::STATUS_WMASK;
        end else if (ctl_wr_ok && ctl_sel_i == cbrf_pkg::CTL_STATUS) begin
            status_reg <= ctl_wdata_i & cbrf_pkg::STATUS_WMASK;
        end
    end

    // saved state, not reset
    always_ff @(posedge sys_clk_i) begin
        if (exc_take_i) begin
            saved_status_reg <= status_reg;
            saved_pc_reg     <= pc_reg;
        end else begin
            if (ctl_wr_ok && ctl_sel_i == cbrf_pkg::CTL_SAVED_STAT) begin
                saved_status_reg <= ctl_wdata_i;
            end
            if (ctl_wr_ok && ctl_sel_i == cbrf_pkg::CTL_SAVED_PC) begin
                saved_pc_reg <= ctl_wdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (ctl_wr_ok && ctl_sel_i == cbrf_pkg::CTL_GLOBAL_BASE) begin
            global_base_reg <= ctl_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            vector_base_reg <= cbrf_pkg::VBR_RESET;
        end else if (ctl_wr_ok && ctl_sel_i == cbrf_pkg::CTL_VECTOR_BASE) begin
            vector_base_reg <= ctl_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system registers; the multiplier's own result wins over a software load
    always_ff @(posedge sys_clk_i) begin
        if (mac_we_i) begin
            acc_high_reg <= mac_high_i;
            acc_low_reg  <= mac_low_i;
        end else if (sys_we_i && sys_sel_i == cbrf_pkg::SYS_ACC_HIGH) begin
            acc_high_reg <= sys_wdata_i;
        end else if (sys_we_i && sys_sel_i == cbrf_pkg::SYS_ACC_LOW) begin
            acc_low_reg <= sys_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (pr_we_i) begin
            proc_ret_reg <= pr_wdata_i;
        end else if (sys_we_i && sys_sel_i == cbrf_pkg::SYS_PROC_RET) begin
            proc_ret_reg <= sys_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // store-side read data, registered
    always_comb begin
        case (sys_sel_i)
            cbrf_pkg::SYS_ACC_HIGH: sys_rdata_next = acc_high_reg;
            cbrf_pkg::SYS_ACC_LOW:  sys_rdata_next = acc_low_reg;
            cbrf_pkg::SYS_PROC_RET: sys_rdata_next = proc_ret_reg;
            default:                sys_rdata_next = pc_reg;
        endcase
    end

    always_comb begin
        if (ctl_sel_i[cbrf_pkg::CTL_BANK_BIT]) begin
            ctl_rdata_next = alt_rdata;
        end else if (ctl_sel_i == cbrf_pkg::CTL_STATUS) begin
            ctl_rdata_next = status_reg;
        end else if (ctl_sel_i == cbrf_pkg::CTL_SAVED_STAT) begin
            ctl_rdata_next = saved_status_reg;
        end else if (ctl_sel_i == cbrf_pkg::CTL_SAVED_PC) begin
            ctl_rdata_next = saved_pc_reg;
        end else if (ctl_sel_i == cbrf_pkg::CTL_GLOBAL_BASE) begin
            ctl_rdata_next = global_base_reg;
        end else if (ctl_sel_i == cbrf_pkg::CTL_VECTOR_BASE) begin
            ctl_rdata_next = vector_base_reg;
        end else begin
            ctl_rdata_next = '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sys_rdata_reg <= '0;
            ctl_rdata_reg <= '0;
            ctl_fault_reg <= 1'b0;
        end else begin
            if (sys_re_i) begin
                sys_rdata_reg <= sys_rdata_next;
            end
            // a refused access leaves the old read data in place
            if (ctl_re_i && ctl_ok) begin
                ctl_rdata_reg <= ctl_rdata_next;
            end
            ctl_fault_reg <= (ctl_re_i | ctl_we_i) & ~ctl_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rd_a_data_o   = rd_a_reg;
    assign rd_b_data_o   = rd_b_reg;
    assign index_data_o  = index_reg;
    assign sys_rdata_o   = sys_rdata_reg;
    assign ctl_rdata_o   = ctl_rdata_reg;
    assign ctl_fault_o   = ctl_fault_reg;
    assign pc_o          = pc_reg;
    assign status_o      = status_reg;
    assign global_base_o = global_base_reg;
    assign vector_base_o = vector_base_reg;

    ////////////////////////////////////////////////////////////////////////////
    a_pc_reset_value: assert property (@(posedge sys_clk_i)
        !rst_n_i |=> pc_reg == cbrf_pkg::PC_RESET)
        else $error("pc not at start address after reset");

    a_vbr_reset_zero: assert property (@(posedge sys_clk_i)
        !rst_n_i |=> vector_base_reg == cbrf_pkg::VBR_RESET)
        else $error("vector base not cleared by reset");

    a_exc_saves_pc: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        exc_take_i |=> saved_pc_reg == $past(pc_reg))
        else $error("saved pc differs from pc at exception");

    a_exc_saves_status: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        exc_take_i |=> saved_status_reg == $past(status_reg))
        else $error("saved status differs from status at exception");

    a_exc_forces_mode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        exc_take_i |=> status_o[cbrf_pkg::MD_BIT] && status_o[cbrf_pkg::RB_BIT]
                       && bank_cur)
        else $error("exception did not force privileged mode and bank one");

    a_rte_restores_pc: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        exc_return_i && !exc_take_i |=> pc_o == $past(saved_pc_reg))
        else $error("exception return did not restore pc");

    a_user_ctl_fault: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (ctl_we_i || ctl_re_i) && !priv_mode
        && ctl_sel_i != cbrf_pkg::CTL_GLOBAL_BASE |=> ctl_fault_o)
        else $error("user access to control register not refused");

    a_gbr_user_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ctl_we_i && ctl_sel_i == cbrf_pkg::CTL_GLOBAL_BASE
        |=> global_base_o == $past(ctl_wdata_i) && !ctl_fault_o)
        else $error("global base write lost");

    a_pc_step_size: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        pc_advance_i && !pc_load_i && !exc_take_i && !exc_return_i
        |=> pc_o == $past(pc_reg) + cbrf_pkg::INSTR_BYTES)
        else $error("pc step wrong");

    a_index_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        gen_we_i && gen_wr_idx_i == {1'b0, cbrf_pkg::INDEX_REG} ##1 $stable(bank_cur)
        |=> index_data_o == $past(gen_wr_data_i, 2))
        else $error("index register output misses a write to register zero");
endmodule // cbrf_regfile
`default_nettype wire

// ==== cbrf_core_model.sv ====
// decode/execute side model: owns every request line of the register file
// assumes each call starts at a falling edge; requests are taken at the next rise
`timescale 1ns/10ps
`default_nettype none
module cbrf_core_model (
    input  wire logic sys_clk_i
);
    logic [3:0]  rd_a_idx, rd_b_idx, wr_idx, ctl_sel;
    logic [1:0]  sys_sel;
    logic        gen_we, sys_we, sys_re, ctl_we, ctl_re, mac_we, pr_we;
    logic        pc_adv, pc_load, exc_take, exc_ret;
    logic [31:0] wr_data, sys_wdata, ctl_wdata, mac_hi, mac_lo, pr_data, target;

    ////////////////////////////////////////////////////////////////////////////
    // strobes, high bit first: gen_we sys_we sys_re ctl_we ctl_re mac_we pr_we
    // exc_take exc_ret pc_load pc_adv; one assignment per call, so back to back
    // calls never write a strobe twice in one time step
    task automatic go(input logic [10:0] s);
        {gen_we, sys_we, sys_re, ctl_we, ctl_re, mac_we, pr_we} = s[10:4];
        {exc_take, exc_ret, pc_load, pc_adv} = s[3:0];
        @(negedge sys_clk_i);
    endtask

    // only where an edge passes next, never right before another call
    task automatic idle();
        {gen_we, sys_we, sys_re, ctl_we, ctl_re, mac_we, pr_we} = 7'h00;
        {pc_adv, pc_load, exc_take, exc_ret} = 4'h0;
        // released data lines change, so a stale value cannot pass for a live one
        {wr_data, sys_wdata, ctl_wdata} = ~{wr_data, sys_wdata, ctl_wdata};
    endtask

    initial begin
        {rd_a_idx, rd_b_idx, wr_idx, ctl_sel, sys_sel} = 18'h00000;
        {wr_data, sys_wdata, ctl_wdata, mac_hi, mac_lo, pr_data, target} = 224'h0;
        {gen_we, sys_we, sys_re, ctl_we, ctl_re, mac_we, pr_we} = 7'h00;
        {pc_adv, pc_load, exc_take, exc_ret} = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic gen_wr(input logic [3:0] i, input logic [31:0] d);
        {wr_idx, wr_data} = {i, d};
        go(11'h400);
    endtask

    task automatic gen_rd(input logic [3:0] i);
        rd_a_idx = i;
        rd_b_idx = ~i;
        go(11'h000);
    endtask

    // w high: load, w low: store
    task automatic sys_op(input logic w, input logic [1:0] s, input logic [31:0] d);
        {sys_sel, sys_wdata} = {s, d};
        go({1'b0, w, ~w, 8'h00});
    endtask

    task automatic ctl_op(input logic w, input logic [3:0] s, input logic [31:0] d);
        {ctl_sel, ctl_wdata} = {s, d};
        go({3'h0, w, ~w, 6'h00});
    endtask

    task automatic mac(input logic [31:0] h, input logic [31:0] l);
        {mac_hi, mac_lo} = {h, l};
        go(11'h020);
    endtask

    task automatic pr(input logic [31:0] d);
        pr_data = d;
        go(11'h010);
    endtask

    // kind: 8 exception, 4 return, 2 branch, 1 advance
    task automatic flow(input logic [3:0] kind, input logic [31:0] t);
        target = t;
        go({7'h00, kind});
    endtask
endmodule // cbrf_core_model
`default_nettype wire

// ==== cbrf_regfile_tb.sv ====
// self-checking bench for the banked register file
// assumes the core model launches every request on a falling edge
`timescale 1ns/10ps
`default_nettype none
module cbrf_regfile_tb;
    logic        sys_clk_i;
    logic        rst_n_i;
    logic        fault;
    logic [31:0] rd_a, rd_b, idx0, sys_rd, ctl_rd, pc, status, gbase, vbase;
    int          error_cnt;
    int          comparisons;

    cbrf_core_model core (
        .sys_clk_i(sys_clk_i)
    );

    cbrf_regfile dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .rd_a_idx_i(core.rd_a_idx), .rd_b_idx_i(core.rd_b_idx), .gen_we_i(core.gen_we),
        .gen_wr_idx_i(core.wr_idx), .gen_wr_data_i(core.wr_data), .rd_a_data_o(rd_a),
        .rd_b_data_o(rd_b), .index_data_o(idx0), .sys_we_i(core.sys_we),
        .sys_re_i(core.sys_re), .sys_sel_i(core.sys_sel), .sys_wdata_i(core.sys_wdata),
        .sys_rdata_o(sys_rd), .ctl_we_i(core.ctl_we), .ctl_re_i(core.ctl_re),
        .ctl_sel_i(core.ctl_sel), .ctl_wdata_i(core.ctl_wdata), .ctl_rdata_o(ctl_rd),
        .ctl_fault_o(fault), .mac_we_i(core.mac_we), .mac_high_i(core.mac_hi),
        .mac_low_i(core.mac_lo), .pr_we_i(core.pr_we), .pr_wdata_i(core.pr_data),
        .pc_advance_i(core.pc_adv), .pc_load_i(core.pc_load), .pc_target_i(core.target),
        .exc_take_i(core.exc_take), .exc_target_i(core.target),
        .exc_return_i(core.exc_ret), .pc_o(pc), .status_o(status),
        .global_base_o(gbase), .vector_base_o(vbase)
    );

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] p(input int b, input int i);
        return {24'h5a5a00 + 24'(b), 8'(i)};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // whole sequence is near 100 cycles; twenty times that means a hang
    initial begin
        #20000;
        error_cnt++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        error_cnt = 0;
        comparisons = 0;
        rst_n_i = 1'b0;
        repeat (12) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        check(pc, cbrf_pkg::PC_RESET);
        check(status, cbrf_pkg::STATUS_RESET);
        check(vbase, cbrf_pkg::VBR_RESET);
        for (int i = 0; i < 16; i++) begin
            core.gen_wr(4'(i), p(1, i));
        end
        for (int i = 0; i < 16; i++) begin
            core.gen_rd(4'(i));
            check(rd_a, p(1, i));
            check(rd_b, p(1, 15 - i));
        end
        check(idx0, p(1, 0));
        core.ctl_op(1'b1, cbrf_pkg::CTL_STATUS, 32'hffffffff);
        check(status, cbrf_pkg::STATUS_WMASK);
        core.ctl_op(1'b1, cbrf_pkg::CTL_STATUS, 32'h400000f0);
        for (int i = 0; i < 8; i++) begin
            core.gen_wr(4'(i), p(0, i));
        end
        for (int i = 0; i < 8; i++) begin
            core.gen_rd(4'(i));
            check(rd_a, p(0, i));
            core.ctl_op(1'b0, 4'(8 + i), 32'h0);
            check(ctl_rd, p(1, i));
        end
        check(idx0, p(0, 0));
        for (int s = 0; s < 3; s++) begin
            core.sys_op(1'b1, 2'(s), p(2, s));
            core.sys_op(1'b0, 2'(s), 32'h0);
            check(sys_rd, p(2, s));
        end
        core.mac(p(3, 0), p(3, 1));
        core.sys_op(1'b0, cbrf_pkg::SYS_ACC_HIGH, 32'h0);
        check(sys_rd, p(3, 0));
        core.sys_op(1'b0, cbrf_pkg::SYS_ACC_LOW, 32'h0);
        check(sys_rd, p(3, 1));
        core.pr(p(3, 2));
        core.sys_op(1'b0, cbrf_pkg::SYS_PROC_RET, 32'h0);
        check(sys_rd, p(3, 2));
        // a load to the program counter must be dropped
        core.sys_op(1'b1, cbrf_pkg::SYS_PROG_CNT, 32'h12345678);
        core.flow(4'h1, 32'h0);
        core.sys_op(1'b0, cbrf_pkg::SYS_PROG_CNT, 32'h0);
        check(sys_rd, 32'ha0000002);
        core.ctl_op(1'b1, cbrf_pkg::CTL_VECTOR_BASE, 32'h8c000000);
        check(vbase, 32'h8c000000);
        core.ctl_op(1'b1, cbrf_pkg::CTL_GLOBAL_BASE, 32'hfffc0000);
        check(gbase, 32'hfffc0000);
        // user mode with bank bit still set: bank zero serves
        core.ctl_op(1'b1, cbrf_pkg::CTL_STATUS, 32'h200000f0);
        core.gen_rd(4'h3);
        check(rd_a, p(0, 3));
        core.ctl_op(1'b1, cbrf_pkg::CTL_VECTOR_BASE, 32'h0);
        check({31'h0, fault}, 32'h1);
        check(vbase, 32'h8c000000);
        core.ctl_op(1'b1, cbrf_pkg::CTL_GLOBAL_BASE, 32'hfffc0100);
        check(gbase, 32'hfffc0100);
        core.ctl_op(1'b0, cbrf_pkg::CTL_GLOBAL_BASE, 32'h0);
        check({31'h0, fault}, 32'h0);
        check(ctl_rd, 32'hfffc0100);
        core.flow(4'h8, 32'h80000100);
        check(pc, 32'h80000100);
        check(status, 32'h700000f0);
        core.ctl_op(1'b0, cbrf_pkg::CTL_SAVED_PC, 32'h0);
        check(ctl_rd, 32'ha0000002);
        core.ctl_op(1'b0, cbrf_pkg::CTL_SAVED_STAT, 32'h0);
        check(ctl_rd, 32'h200000f0);
        core.ctl_op(1'b1, cbrf_pkg::CTL_SAVED_PC, 32'h8c001000);
        core.flow(4'h4, 32'h0);
        check(pc, 32'h8c001000);
        check(status, 32'h200000f0);
        core.idle();
        rst_n_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        check(pc, cbrf_pkg::PC_RESET);
        check(vbase, cbrf_pkg::VBR_RESET);
        check(status, cbrf_pkg::STATUS_RESET);
        core.gen_rd(4'h9);
        check(rd_a, p(1, 9));
        check(rd_b, p(1, 6));
        check(gbase, 32'hfffc0100);
        // branch and step in one cycle: the branch wins
        core.flow(4'h3, 32'h8c002000);
        check(pc, 32'h8c002000);
        give_verdict();
    end
endmodule // cbrf_regfile_tb
`default_nettype wire
